//--- design/sms_pkg.sv
// Constants and carrier types for the supply monitor and status block
package sms_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam logic [5:0] CHECKSUM_ADDR = 6'h00;
  localparam logic [5:0] STATUS_ADDR = 6'h01;
  localparam int unsigned STAT_LOCK_POS = 0;
  localparam int unsigned STAT_PARITY_POS = 1;
  localparam int unsigned STAT_BROWNOUT_POS = 2;
  localparam int unsigned STAT_RSVD_POS = 3;
  localparam int unsigned STAT_EARLY_POS = 4;
  localparam int unsigned STAT_DEEP_POS = 5;
  localparam int unsigned STAT_ONE_POS = 7;
  localparam logic LOCK_RST = 1'b0;
  localparam logic PARITY_RST = 1'b0;
  localparam logic BROWNOUT_RST = 1'b1;
  localparam logic EARLY_RST = 1'b0;
  localparam logic DEEP_RST = 1'b0;
  localparam logic [7:0] CHECKSUM_RST = 8'h00;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned RESTART_NS = 1000;
  localparam int unsigned RESTART_CYCLES =
    (RESTART_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W = 8;

  typedef enum logic [1:0] {
    SMS_RUN = 2'b00,
    SMS_RESTART = 2'b01
  } sms_state_type;

  // Analog comparator outputs, high while the supply is below threshold
  typedef struct packed {
    logic regulated_supply_line_low;
    logic vbat_low;
    logic below_early;
    logic below_deep;
  } sms_sense_type;

  typedef struct packed {
    logic deep;
    logic early;
    logic brownout;
    logic parity;
    logic lock;
  } sms_flags_type;
endpackage : sms_pkg

//--- design/sms_flag.sv
// Sticky status flag with set priority and synchronous reload
`timescale 1ns/1ps
`default_nettype none
module sms_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic reload,
  input wire logic set,
  input wire logic clr,
  output logic flag_q
);
  always_ff @(posedge sys_clk) begin
    if (!rst_b || reload) begin
      flag_q <= RESET_VAL;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule : sms_flag
`default_nettype wire

//--- design/sms_supply_monitor.sv
// Supply monitor, power state control and status register of the transmitter
//
// Summary of operation
// - Host reaches registers only through serial port
// - Brownout: amplifier off, registers reset, restart
// - Watch regulator; also battery while in standby
// - Brownout recorded in status bit two
// - Early flag bit four, deep flag bit five
// - Early flag sets below upper warning level
// - Transmission start clears both battery flags, except one its comparator sets in the same cycle
// - Standby keeps serial, registers powered, core off
// - Sleep powers serial only, registers lost
// - Parity flag bit one, lock flag bit zero
// - Checksum clears on its own read, brownout or sleep entry only
`timescale 1ns/1ps
`default_nettype none
module sms_supply_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire sms_pkg::sms_sense_type sense,
  input wire logic standby,
  input wire logic sleep,
  input wire logic tx_start,
  input wire logic parity_err_evt,
  input wire logic lock_err_evt,
  input wire logic chk_byte_valid,
  input wire logic [7:0] chk_byte,
  input wire logic reg_rd_en,
  input wire logic [5:0] reg_addr,
  output logic [7:0] reg_rd_data_q,
  output logic pa_off,
  output logic config_reset,
  output logic core_pwr_en,
  output logic retained_pwr_en
);
  sms_pkg::sms_state_type state_q;
  logic [sms_pkg::CNT_W-1:0] cnt_q;
  logic sleep_q;
  logic bod_trip;
  logic sleep_entry;
  logic reload;
  logic active;
  logic rd_status;
  logic rd_checksum;
  logic [7:0] checksum_q;
  logic [7:0] status_byte;
  sms_pkg::sms_flags_type flags;

  // Standby adds the battery to the watched lines
  assign bod_trip = sense.regulated_supply_line_low || (standby && sense.vbat_low);
  assign sleep_entry = sleep && !sleep_q;
  // Register contents are lost on brownout and on entry to sleep
  assign reload = bod_trip || sleep_entry;
  assign config_reset = reload || state_q == sms_pkg::SMS_RESTART;
  assign active = state_q == sms_pkg::SMS_RUN && !standby && !sleep;
  assign rd_status = reg_rd_en && reg_addr == sms_pkg::STATUS_ADDR;
  assign rd_checksum = reg_rd_en && reg_addr == sms_pkg::CHECKSUM_ADDR;

  // Amplifier held off from the trip until the restart completes
  assign pa_off = bod_trip || state_q != sms_pkg::SMS_RUN;
  assign core_pwr_en = active;
  assign retained_pwr_en = !sleep;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep;
    end
  end

  // Restart sequence mimics the power-up reset hold
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= sms_pkg::SMS_RUN;
      cnt_q <= '0;
    end else if (bod_trip) begin
      state_q <= sms_pkg::SMS_RESTART;
      cnt_q <= sms_pkg::CNT_W'(sms_pkg::RESTART_CYCLES - 1);
    end else begin
      unique case (state_q)
        sms_pkg::SMS_RUN: begin
          cnt_q <= '0;
        end
        sms_pkg::SMS_RESTART: begin
          if (cnt_q == '0) begin
            state_q <= sms_pkg::SMS_RUN;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= sms_pkg::SMS_RUN;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Brownout reloads its own reset value of one, which records the event
  sms_flag #(.RESET_VAL(sms_pkg::BROWNOUT_RST)) u_brownout (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .reload(reload),
    .set(1'b0),
    .clr(rd_status && state_q == sms_pkg::SMS_RUN),
    .flag_q(flags.brownout)
  );

  sms_flag #(.RESET_VAL(sms_pkg::PARITY_RST)) u_parity (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .reload(reload),
    .set(parity_err_evt),
    .clr(rd_status),
    .flag_q(flags.parity)
  );

  sms_flag #(.RESET_VAL(sms_pkg::LOCK_RST)) u_lock (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .reload(reload),
    .set(lock_err_evt),
    .clr(rd_status),
    .flag_q(flags.lock)
  );

  // Battery comparators count only in active modes
  sms_flag #(.RESET_VAL(sms_pkg::EARLY_RST)) u_early (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .reload(reload),
    .set(active && sense.below_early),
    .clr(tx_start),
    .flag_q(flags.early)
  );

  sms_flag #(.RESET_VAL(sms_pkg::DEEP_RST)) u_deep (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .reload(reload),
    .set(active && sense.below_deep),
    .clr(tx_start),
    .flag_q(flags.deep)
  );

  always_comb begin
    status_byte = 8'h00;
    status_byte[sms_pkg::STAT_ONE_POS] = 1'b1;
    status_byte[sms_pkg::STAT_DEEP_POS] = flags.deep;
    status_byte[sms_pkg::STAT_EARLY_POS] = flags.early;
    status_byte[sms_pkg::STAT_RSVD_POS] = 1'b0;
    status_byte[sms_pkg::STAT_BROWNOUT_POS] = flags.brownout;
    status_byte[sms_pkg::STAT_PARITY_POS] = flags.parity;
    status_byte[sms_pkg::STAT_LOCK_POS] = flags.lock;
  end

  // Running XOR of write bytes; a byte arriving with the read survives
  always_ff @(posedge sys_clk) begin
    if (!rst_b || reload) begin
      checksum_q <= sms_pkg::CHECKSUM_RST;
    end else if (chk_byte_valid) begin
      checksum_q <= (rd_checksum ? 8'h00 : checksum_q) ^ chk_byte;
    end else if (rd_checksum) begin
      checksum_q <= 8'h00;
    end
  end

  // Addresses outside this block answer zero; the bank lives elsewhere
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rd_data_q <= 8'h00;
    end else if (rd_status) begin
      reg_rd_data_q <= status_byte;
    end else if (rd_checksum) begin
      reg_rd_data_q <= checksum_q;
    end else if (reg_rd_en) begin
      reg_rd_data_q <= 8'h00;
    end
  end

  // Cycles since the last trip, saturating; long holds checked by count
  logic [sms_pkg::CNT_W-1:0] quiet_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      quiet_q <= '1;
    end else if (bod_trip) begin
      quiet_q <= '0;
    end else if (quiet_q != '1) begin
      quiet_q <= quiet_q + 1'b1;
    end
  end

  sequence s_trip;
    bod_trip;
  endsequence

  sequence s_restart_hold;
    pa_off && config_reset;
  endsequence

  AST_TRIP_RESTARTS: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    s_trip |=> s_restart_hold [*2])
    else $error("Brownout did not hold restart");
  AST_RESTART_HOLDS: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    quiet_q < sms_pkg::CNT_W'(sms_pkg::RESTART_CYCLES) |-> s_restart_hold)
    else $error("Restart ended early");
  AST_RESTART_ENDS: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (quiet_q >= sms_pkg::CNT_W'(sms_pkg::RESTART_CYCLES) && !bod_trip)
    |-> !pa_off)
    else $error("Restart did not finish");
  AST_STANDBY_VBAT: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (standby && sense.vbat_low) |=> state_q == sms_pkg::SMS_RESTART)
    else $error("Battery brownout in standby missed");
  AST_ACTIVE_VBAT_IGNORED: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (!standby && sense.vbat_low && !sense.regulated_supply_line_low) |-> !bod_trip)
    else $error("Battery watched outside standby");
  AST_BROWNOUT_FLAG: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    s_trip |=> flags.brownout)
    else $error("Brownout not recorded");
  AST_EARLY_SET: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (active && sense.below_early && !reload) |=> flags.early)
    else $error("Early battery flag not set");
  AST_TX_CLEARS: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (tx_start && !(active && (sense.below_early || sense.below_deep)))
    |=> !flags.early && !flags.deep)
    else $error("Battery flags survive transmission start");
  AST_READ_CLEARS: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (rd_status && !parity_err_evt && !reload) |=> !flags.parity
    && reg_rd_data_q[1] == $past(status_byte[1]))
    else $error("Parity flag not cleared by read");
  AST_SLEEP_POWER: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    sleep |-> !core_pwr_en && !retained_pwr_en)
    else $error("Power left on in sleep");
  AST_CHECKSUM_KEPT: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (rd_status && !chk_byte_valid && !reload) |=> $stable(checksum_q))
    else $error("Checksum disturbed by other read");
endmodule : sms_supply_monitor
`default_nettype wire

//--- dv/sms_host_model.sv
// Host model issuing serial register reads and write bytes
`timescale 1ns/1ps
`default_nettype none
module sms_host_model (
  input wire logic sys_clk,
  output logic reg_rd_en,
  output logic [5:0] reg_addr,
  output logic chk_byte_valid,
  output logic [7:0] chk_byte
);
  initial begin
    reg_rd_en = 1'b0;
    reg_addr = 6'h3F;
    chk_byte_valid = 1'b0;
    chk_byte = 8'hA5;
  end
  task automatic rd(input logic [5:0] a);
    @(posedge sys_clk);
    #1 reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1 reg_rd_en = 1'b0;
    reg_addr = ~a; // Released lines never keep the last value
  endtask : rd
  task automatic wr(input logic [7:0] b);
    @(posedge sys_clk);
    #1 chk_byte_valid = 1'b1;
    chk_byte = b;
    @(posedge sys_clk);
    #1 chk_byte_valid = 1'b0;
    chk_byte = ~b;
  endtask : wr
endmodule : sms_host_model
`default_nettype wire

//--- dv/sms_supply_monitor_bench.sv
// Self-checking bench for the supply monitor and status block
`timescale 1ns/1ps
`default_nettype none
module sms_supply_monitor_bench;
  logic sys_clk, rst_b, standby, sleep, tx_start, pe, le, pend;
  logic rd_en, chk_v, pa_off, cfg_rst, core_en, ret_en;
  sms_pkg::sms_sense_type sense;
  logic [5:0] addr;
  logic [7:0] chk_b, rd_q, sum, b;
  logic [7:0] exp_q[$];
  int n_errors, check_count, n;
  sms_supply_monitor dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .sense(sense), .standby(standby), .sleep(sleep),
    .tx_start(tx_start), .parity_err_evt(pe), .lock_err_evt(le),
    .chk_byte_valid(chk_v), .chk_byte(chk_b), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_rd_data_q(rd_q), .pa_off(pa_off),
    .config_reset(cfg_rst), .core_pwr_en(core_en),
    .retained_pwr_en(ret_en));
  sms_host_model host (.sys_clk(sys_clk), .reg_rd_en(rd_en),
    .reg_addr(addr), .chk_byte_valid(chk_v), .chk_byte(chk_b));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic end_of_test;
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %0t read %h want %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %0t level %b want %b", $time, got, exp);
    end
  endtask : cmp1
  // Read data lands one edge after the strobe is taken
  always @(posedge sys_clk) begin
    #2;
    if (pend) begin
      cmp8(rd_q, exp_q.pop_front());
    end
    pend = rd_en & rst_b;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask : rd
  task automatic trip(input logic [3:0] s, input logic sb);
    sense = s;
    standby = sb;
    tick(1);
    cmp1(pa_off, 1'b1);
    cmp1(cfg_rst, 1'b1);
    sense = 4'h0;
    standby = 1'b0;
    n = 0;
    while (pa_off === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    cmp1(n >= 48 && n <= 52, 1'b1);
    if (n == 200) end_of_test();
    rd(6'h01, 8'h84);
    rd(6'h00, 8'h00);
  endtask : trip
  initial begin
    {rst_b, standby, sleep, tx_start, pe, le} = 6'h00;
    sense = 4'h0;
    n_errors = 0;
    check_count = 0;
    void'($urandom(32'hC9BC56A5));
    tick(20);
    rst_b = 1'b1;
    cmp1(core_en & ret_en, 1'b1);
    rd(6'h01, 8'h84);
    rd(6'h01, 8'h80);
    {pe, le} = 2'h3;
    tick(1);
    {pe, le} = 2'h0;
    rd(6'h01, 8'h83);
    rd(6'h01, 8'h80);
    for (int i = 2; i < 4; i++) begin
      sense = 4'(i);
      tick(2);
      sense = 4'h0;
      rd(6'h01, i == 2 ? 8'h90 : 8'hB0);
      rd(6'h01, i == 2 ? 8'h90 : 8'hB0);
      tx_start = 1'b1;
      tick(1);
      tx_start = 1'b0;
      rd(6'h01, 8'h80);
    end
    sense = 4'h4;
    tick(1);
    cmp1(pa_off, 1'b0);
    standby = 1'b1;
    sense = 4'h2; // No status read while idle
    tick(2);
    cmp1(core_en, 1'b0);
    cmp1(ret_en, 1'b1);
    sense = 4'h0;
    standby = 1'b0;
    rd(6'h01, 8'h80);
    sum = 8'h00;
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom);
      sum ^= b;
      host.wr(b);
    end
    rd(6'h01, 8'h80);
    rd(6'h00, sum);
    rd(6'h00, 8'h00);
    rd(6'($urandom_range(2, 63)), 8'h00);
    host.wr(8'h5A); // Checksum must not survive the trip
    trip(4'h8, 1'b0);
    trip(4'h4, 1'b1);
    pe = 1'b1;
    tick(1);
    pe = 1'b0;
    sleep = 1'b1;
    tick(2);
    cmp1(ret_en | core_en, 1'b0);
    sleep = 1'b0;
    rd(6'h01, 8'h84);
    tick(3);
    end_of_test();
  end
endmodule : sms_supply_monitor_bench
`default_nettype wire
